// File: design/tpm_pkg.sv
// constants, register map and types for the performance counter bank
// Operation
// [R1] 8-bit transmit slip count since last read
// [R2] count each repeated or dropped frame
// [R3] counters clear when read, report new events
// [R4] 16-bit receive excessive zero violation count
// [R5] upper byte address shows bits 15..8
// [R6] lower byte address shows bits 7..0
// [R7] software reads upper byte before lower byte
// [R8] upper then lower read clears 16-bit count
// [R9] upper read snapshots lower byte, keeps events
// [R10] 8-bit link 2 checksum error count
// [R11] 8-bit link 3 checksum error count
// [R12] counters stop at all ones, never wrap
package tpm_pkg;

	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_TX_SLIP     = 16'h090F;
	localparam logic [15:0] IDX_ZV_UPPER    = 16'h0910;
	localparam logic [15:0] IDX_ZV_LOWER    = 16'h0911;
	localparam logic [15:0] IDX_LINK2_FCS   = 16'h091C;
	localparam logic [15:0] IDX_LINK3_FCS   = 16'h092C;
	localparam logic [15:0] IDX_IRQ_STATUS  = 16'h0940;
	localparam logic [15:0] IDX_IRQ_MASK    = 16'h0941;

	localparam logic [15:0] ADDR_TX_SLIP    = {IDX_TX_SLIP[13:0], 2'b00};
	localparam logic [15:0] ADDR_ZV_UPPER   = {IDX_ZV_UPPER[13:0], 2'b00};
	localparam logic [15:0] ADDR_ZV_LOWER   = {IDX_ZV_LOWER[13:0], 2'b00};
	localparam logic [15:0] ADDR_LINK2_FCS  = {IDX_LINK2_FCS[13:0], 2'b00};
	localparam logic [15:0] ADDR_LINK3_FCS  = {IDX_LINK3_FCS[13:0], 2'b00};
	localparam logic [15:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS[13:0], 2'b00};
	localparam logic [15:0] ADDR_IRQ_MASK   = {IDX_IRQ_MASK[13:0], 2'b00};

	// counter slots and widths
	localparam int          NUM_CNT         = 4;
	localparam int          CNT_TX_SLIP     = 0;
	localparam int          CNT_ZV          = 1;
	localparam int          CNT_LINK2       = 2;
	localparam int          CNT_LINK3       = 3;
	localparam int          W_SHORT         = 8;
	localparam int          W_LONG          = 16;

	// interrupt status / mask field positions
	localparam int          NUM_IRQ         = 5;
	localparam int          IRQ_SAT         = 4;
	localparam logic [7:0]  RST_COUNT       = 8'h00;
	localparam logic [4:0]  RST_IRQ_STATUS  = 5'h00;
	localparam logic [4:0]  RST_IRQ_MASK    = 5'h00;

	// upper/lower read pairing of the 16-bit counter
	typedef enum logic [0:0] {
		TPM_PAIR_IDLE = 1'b0,
		TPM_PAIR_HELD = 1'b1
	} tpm_pair_t;

endpackage : tpm_pkg

// File: design/tpm_cnt_if.sv
// link between the register front end and one event counter
`timescale 1ns/1ps
interface tpm_cnt_if #(
	parameter int WIDTH = 8
);
	logic             inc;
	logic             clr;
	logic [WIDTH-1:0] value;
	logic             hit_max;

	modport cnt (input inc, input clr, output value, output hit_max);
	modport ctl (output inc, output clr, input value, input hit_max);
endinterface : tpm_cnt_if

// File: design/tpm_counter.sv
// saturating clear-on-read event counter
`timescale 1ns/1ps
module tpm_counter #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// control and count
	tpm_cnt_if.cnt    bus
);
	localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};
	localparam logic [WIDTH-1:0] MAX = {WIDTH{1'b1}};

	logic [WIDTH-1:0] count_q;
	logic             hit_q;

	// [R3] restart on read
	// an event in the clearing cycle becomes the first count of the
	// new interval so no event is lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= '0;
		end else if (bus.clr) begin
			count_q <= bus.inc ? ONE : '0;
		end else if (bus.inc && count_q != MAX) begin
			// [R12] stop at all ones
			count_q <= count_q + ONE;
		end
	end

	// one-cycle pulse when the count first reaches all ones
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hit_q <= 1'b0;
		end else begin
			hit_q <= bus.inc && !bus.clr && (count_q == MAX - ONE);
		end
	end

	assign bus.value   = count_q;
	assign bus.hit_max = hit_q;
endmodule : tpm_counter

// File: design/tpm_bank.sv
// performance counter bank with apb register access and interrupt
`timescale 1ns/1ps
module tpm_bank #(
	parameter int PADDR_W = 16
) (
	// clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// apb slave
	input  wire logic [PADDR_W-1:0] paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	input  wire logic [3:0]         pstrb,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// event pulses from framer logic, same clock
	input  wire logic               transmit_slip_tally_evt,
	input  wire logic               zero_violation_tally_evt,
	input  wire logic               link2_checksum_error_tally_evt,
	input  wire logic               link3_checksum_error_tally_evt,
	// interrupt
	output logic                    irq
);
	logic [tpm_pkg::NUM_CNT-1:0]  evt;
	logic [tpm_pkg::NUM_CNT-1:0]  cnt_clr;
	logic [tpm_pkg::NUM_CNT-1:0]  cnt_hit;
	logic [15:0]                  cnt_val [tpm_pkg::NUM_CNT];

	logic                         setup;
	logic                         rd_setup;
	logic                         wr_setup;
	logic [15:0]                  addr;
	logic                         aligned;

	logic [7:0]                   rd_byte;
	logic                         rd_hit;

	tpm_pkg::tpm_pair_t           pair_q;
	tpm_pkg::tpm_pair_t           pair_d;
	logic [7:0]                   zv_snap_q;

	logic [tpm_pkg::NUM_IRQ-1:0]  irq_set;
	logic [tpm_pkg::NUM_IRQ-1:0]  irq_w1c;
	logic [tpm_pkg::NUM_IRQ-1:0]  irq_status_q;
	logic [tpm_pkg::NUM_IRQ-1:0]  irq_mask_q;
	logic                         irq_q;

	logic [31:0]                  prdata_q;
	logic                         pslverr_q;

	// [R2] slip pulse per repeated or dropped frame
	assign evt[tpm_pkg::CNT_TX_SLIP] = transmit_slip_tally_evt;
	// [R4] zero violation events
	assign evt[tpm_pkg::CNT_ZV]      = zero_violation_tally_evt;
	// [R10] link 2 checksum errors
	assign evt[tpm_pkg::CNT_LINK2]   = link2_checksum_error_tally_evt;
	// [R11] link 3 checksum errors
	assign evt[tpm_pkg::CNT_LINK3]   = link3_checksum_error_tally_evt;

	// counters: slot CNT_ZV is 16 bits wide, the others 8 bits
	genvar gi;
	generate
		for (gi = 0; gi < tpm_pkg::NUM_CNT; gi++) begin : g_cnt
			localparam int W = (gi == tpm_pkg::CNT_ZV) ?
				tpm_pkg::W_LONG : tpm_pkg::W_SHORT;
			tpm_cnt_if #(.WIDTH(W)) cif ();
			tpm_counter #(
				.WIDTH   (W)
			) u_cnt (
				.pclk    (pclk),
				.presetn (presetn),
				.bus     (cif.cnt)
			);
			assign cif.inc     = evt[gi];
			assign cif.clr     = cnt_clr[gi];
			assign cnt_hit[gi] = cif.hit_max;
			if (W == tpm_pkg::W_LONG) begin : g_long
				assign cnt_val[gi] = cif.value;
			end else begin : g_short
				assign cnt_val[gi] = {8'h00, cif.value};
			end
		end
	endgenerate

	// every register effect lands on the setup edge, the same edge that
	// loads read data, so no event can slip between capture and clear
	assign setup    = psel && !penable;
	assign rd_setup = setup && !pwrite;
	assign wr_setup = setup && pwrite;
	assign addr     = 16'(paddr);
	assign aligned  = (addr[1:0] == 2'b00);

	// read mux and clear-on-read selection
	always_comb begin
		rd_byte = 8'h00;
		rd_hit  = 1'b1;
		cnt_clr = '0;
		pair_d  = pair_q;
		if (!aligned) begin
			rd_hit = 1'b0;
		end else if (addr == tpm_pkg::ADDR_TX_SLIP) begin
			rd_byte = cnt_val[tpm_pkg::CNT_TX_SLIP][7:0];
			// [R1] clear slip count on read
			cnt_clr[tpm_pkg::CNT_TX_SLIP] = rd_setup;
		end else if (addr == tpm_pkg::ADDR_ZV_UPPER) begin
			// [R5] upper byte bits 15..8
			rd_byte = cnt_val[tpm_pkg::CNT_ZV][15:8];
			// [R9] snapshot lower byte, restart
			cnt_clr[tpm_pkg::CNT_ZV] = rd_setup;
			if (rd_setup) begin
				pair_d = tpm_pkg::TPM_PAIR_HELD;
			end
		end else if (addr == tpm_pkg::ADDR_ZV_LOWER) begin
			// [R6] lower byte bits 7..0
			// [R8] held pair ends here; the count was already cleared by the upper read
			if (pair_q == tpm_pkg::TPM_PAIR_HELD) begin
				rd_byte = zv_snap_q;
				if (rd_setup) begin
					pair_d = tpm_pkg::TPM_PAIR_IDLE;
				end
			end else begin
				// [R7] out-of-order read is live, no clear
				rd_byte = cnt_val[tpm_pkg::CNT_ZV][7:0];
			end
		end else if (addr == tpm_pkg::ADDR_LINK2_FCS) begin
			rd_byte = cnt_val[tpm_pkg::CNT_LINK2][7:0];
			// [R10] clear link 2 on read
			cnt_clr[tpm_pkg::CNT_LINK2] = rd_setup;
		end else if (addr == tpm_pkg::ADDR_LINK3_FCS) begin
			rd_byte = cnt_val[tpm_pkg::CNT_LINK3][7:0];
			// [R11] clear link 3 on read
			cnt_clr[tpm_pkg::CNT_LINK3] = rd_setup;
		end else if (addr == tpm_pkg::ADDR_IRQ_STATUS) begin
			rd_byte = {3'b000, irq_status_q};
		end else if (addr == tpm_pkg::ADDR_IRQ_MASK) begin
			rd_byte = {3'b000, irq_mask_q};
		end else begin
			rd_hit = 1'b0;
		end
	end

	// pairing state of the 16-bit counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pair_q <= tpm_pkg::TPM_PAIR_IDLE;
		end else begin
			pair_q <= pair_d;
		end
	end

	// [R9] lower byte frozen at upper read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zv_snap_q <= tpm_pkg::RST_COUNT;
		end else if (rd_setup && aligned &&
			addr == tpm_pkg::ADDR_ZV_UPPER) begin
			zv_snap_q <= cnt_val[tpm_pkg::CNT_ZV][7:0];
		end
	end

	// interrupt sources: one per counter plus any counter saturating
	assign irq_set = {|cnt_hit, evt};
	assign irq_w1c = (wr_setup && aligned && pstrb[0] &&
		addr == tpm_pkg::ADDR_IRQ_STATUS) ?
		pwdata[tpm_pkg::NUM_IRQ-1:0] : '0;

	// sticky status; a new event wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_q <= tpm_pkg::RST_IRQ_STATUS;
		end else begin
			irq_status_q <= (irq_status_q & ~irq_w1c) | irq_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_q <= tpm_pkg::RST_IRQ_MASK;
		end else if (wr_setup && aligned && pstrb[0] &&
			addr == tpm_pkg::ADDR_IRQ_MASK) begin
			irq_mask_q <= pwdata[tpm_pkg::NUM_IRQ-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_status_q & irq_mask_q);
		end
	end

	// read data and error captured at setup, shown in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (setup) begin
			prdata_q  <= (rd_setup && rd_hit) ? {24'h00_0000, rd_byte}
				: 32'h0000_0000;
			pslverr_q <= !rd_hit;
		end
	end

	// zero wait states: every access phase completes at once
	assign pready  = 1'b1;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;
	assign irq     = irq_q;
endmodule : tpm_bank

// File: verif/tpm_bank_asserts.sv
// bus and counter checker bound to the counter bank
`timescale 1ns/1ps
module tpm_bank_asserts #(
	parameter int PADDR_W = 16
) (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic [PADDR_W-1:0] paddr,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic               transmit_slip_tally_evt,
	input wire logic               irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic map;
	assign map = paddr inside {tpm_pkg::ADDR_TX_SLIP, tpm_pkg::ADDR_ZV_UPPER,
		tpm_pkg::ADDR_ZV_LOWER, tpm_pkg::ADDR_LINK2_FCS,
		tpm_pkg::ADDR_LINK3_FCS, tpm_pkg::ADDR_IRQ_STATUS,
		tpm_pkg::ADDR_IRQ_MASK};
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_slip;
		s_setup ##0 (!pwrite && paddr == tpm_pkg::ADDR_TX_SLIP);
	endsequence
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_data_width: assert property (psel && penable |-> !prdata[31:8])
		else $error("upper read bits set");
	a_unmapped_err: assert property (s_setup ##0 !map |=> pslverr)
		else $error("no error on unmapped");
	a_mapped_ok: assert property (s_setup ##0 map |=> !pslverr)
		else $error("error on mapped");
	a_err_data: assert property (penable && pslverr |-> prdata == 32'h0)
		else $error("data on error");
	a_data_holds: assert property (s_setup ##1 penable |=> $stable(prdata))
		else $error("read data moved");
	// no slip between two reads leaves nothing to report
	a_clear_read: assert property (
		(s_slip ##0 !transmit_slip_tally_evt) ##1
		(penable && !transmit_slip_tally_evt) ##1 s_slip |=> prdata == 32'h0)
		else $error("count not cleared");
	a_reset_quiet: assert property ($rose(presetn) |-> !irq && !pslverr)
		else $error("outputs busy after reset");
endmodule : tpm_bank_asserts
bind tpm_bank tpm_bank_asserts #(.PADDR_W(PADDR_W)) u_chk (.pclk(pclk),
	.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.transmit_slip_tally_evt(transmit_slip_tally_evt), .irq(irq));

// File: verif/test_tpm_bank.sv
// self-checking bench for the counter bank
`timescale 1ns/1ps
module test_tpm_bank;
	localparam logic [15:0] ADR [4] = '{tpm_pkg::ADDR_TX_SLIP,
		tpm_pkg::ADDR_ZV_UPPER, tpm_pkg::ADDR_LINK2_FCS,
		tpm_pkg::ADDR_LINK3_FCS};
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0]  evt = 4'h0;
	logic        pready, pslverr, irq;
	logic [32:0] exp_q [$];
	logic [32:0] got;
	int          cnt [4], miscompares, compares, cyc;
	tpm_bank dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.transmit_slip_tally_evt(evt[0]), .zero_violation_tally_evt(evt[1]),
		.link2_checksum_error_tally_evt(evt[2]),
		.link3_checksum_error_tally_evt(evt[3]), .irq(irq));
	initial forever #4 pclk = ~pclk;
	task automatic end_of_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_of_test
	task automatic apb(logic [15:0] a, logic w, logic [31:0] d, logic [32:0] e);
		if (!w) exp_q.push_back(e);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
	endtask : apb
	// upper read moves the low byte aside, lower read returns it
	task automatic rdk(int k);
		int s;
		s = cnt[k] & 255;
		apb(ADR[k], 0, 0, {1'b0, 32'(k == 1 ? cnt[k] >> 8 : cnt[k])});
		cnt[k] = 0;
		if (k == 1) apb(tpm_pkg::ADDR_ZV_LOWER, 0, 0, {1'b0, 32'(s)});
	endtask : rdk
	// releases the bus, then n single-cycle events; n of 0 just idles
	task automatic pulse(int k, int n);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (n) begin
			evt[k] <= 1'b1;
			@(posedge pclk);
		end
		evt[k] <= 1'b0;
		@(posedge pclk);
		cnt[k] = cnt[k] + n;
		if (cnt[k] > (k == 1 ? 65535 : 255)) cnt[k] = (k == 1 ? 65535 : 255);
	endtask : pulse
	task automatic chk(logic c);
		compares++;
		if (c !== 1'b1) begin
			miscompares++;
			$display("ERROR %0t irq level wrong", $time);
		end
	endtask : chk
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			end_of_test();
		end else if (presetn && psel && penable && pready && !pwrite) begin
			got = exp_q.pop_front();
			compares++;
			if ({pslverr, prdata} !== got) begin
				miscompares++;
				$display("ERROR %0t want %h got %h", $time, got, {pslverr, prdata});
			end
		end
	end
	initial begin
		void'($urandom(32'h5d7404d1));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int k = 0; k < 4; k++) begin
			rdk(k);
			pulse(k, $urandom_range(1, 40));
			rdk(k);
			rdk(k);
		end
		pulse(1, 300);
		apb(tpm_pkg::ADDR_ZV_UPPER, 0, 0, 33'h1);
		pulse(1, 3);
		apb(tpm_pkg::ADDR_ZV_LOWER, 0, 0, 33'h2C);
		cnt[1] = 3;
		rdk(1);
		pulse(1, 5);
		apb(tpm_pkg::ADDR_ZV_LOWER, 0, 0, 33'h5);
		rdk(1);
		pulse(0, 260);
		rdk(0);
		pulse(2, 7);
		apb(tpm_pkg::ADDR_LINK2_FCS, 1, 32'h0, 33'h0);
		apb(16'h0000, 0, 0, {1'b1, 32'h0});
		apb(tpm_pkg::ADDR_TX_SLIP + 16'h1, 0, 0, {1'b1, 32'h0});
		rdk(2);
		chk(irq === 1'b0);
		// every source has fired, saturation included
		apb(tpm_pkg::ADDR_IRQ_STATUS, 0, 0, 33'h1F);
		apb(tpm_pkg::ADDR_IRQ_STATUS, 1, 32'h1F, 33'h0);
		apb(tpm_pkg::ADDR_IRQ_MASK, 1, 32'h1, 33'h0);
		pulse(0, 1);
		@(posedge pclk);
		chk(irq === 1'b1);
		pulse(2, 1);
		apb(tpm_pkg::ADDR_IRQ_STATUS, 0, 0, 33'h5);
		apb(tpm_pkg::ADDR_IRQ_STATUS, 1, 32'h1, 33'h0);
		pulse(0, 0);
		@(posedge pclk);
		chk(irq === 1'b0);
		end_of_test();
	end
endmodule : test_tpm_bank
